// ===== verilog/ctx_consts.vh
`ifndef CTX_CONSTS_VH
`define CTX_CONSTS_VH
// ****************************************************************
// Register map (APB byte offsets)
// ****************************************************************
`define CTX_OFS_CTRL 8'h00
`define CTX_OFS_INSTR 8'h04
`define CTX_OFS_EXT 8'h08
`define CTX_OFS_OPND 8'h0c
`define CTX_OFS_OPHI 8'h10
`define CTX_OFS_FLAGS 8'h14
`define CTX_OFS_RESULT 8'h18
`define CTX_OFS_STATUS 8'h1c
// ****************************************************************
// Field positions
// ****************************************************************
`define CTX_CTRL_START 0
`define CTX_CTRL_SEG 1
`define CTX_CTRL_LONGSEG 2
`define CTX_FLG_C 7
`define CTX_FLG_Z 6
`define CTX_FLG_S 5
`define CTX_FLG_PV 4
`define CTX_ST_BUSY 0
`define CTX_ST_DONE 1
`define CTX_ST_ILL 2
`define CTX_ST_WB 3
// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CTX_OP_CSET 7'h57
`define CTX_OP_TEST_WB 5'h06
`define CTX_OP_TEST_L 6'h1c
`define CTX_NIB_TEST_WB 4'h4
`define CTX_NIB_TEST_L 4'h8
`define CTX_MODE_IR 2'h0
`define CTX_MODE_DA 2'h1
`define CTX_MODE_R 2'h2
// ****************************************************************
// Cycle counts
// ****************************************************************
`define CTX_CYC_CSET 5'd5
`define CTX_CYC_R_WB 5'd7
`define CTX_CYC_R_L 5'd13
`define CTX_CYC_IR_WB 5'd8
`define CTX_CYC_IR_L 5'd13
`define CTX_CYC_DA_WB_NS 5'd11
`define CTX_CYC_DA_WB_SS 5'd12
`define CTX_CYC_DA_WB_SL 5'd14
`define CTX_CYC_DA_L_NS 5'd16
`define CTX_CYC_DA_L_SS 5'd17
`define CTX_CYC_DA_L_SL 5'd19
`define CTX_CYC_X_WB_S 5'd12
`define CTX_CYC_X_WB_SL 5'd15
`define CTX_CYC_X_L_S 5'd17
`define CTX_CYC_X_L_SL 5'd20
`define CTX_RESET_WORD 32'h0000_0000
`endif

// ===== verilog/ctx_exec.v
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Behaviour
// - A true condition sets bit 0 of the destination.
// - A false condition leaves bit 0 at its prior value.
// - Conditional set changes no bit other than bit 0, any size.
// - Condition tested against flag control word; flags stay unchanged.
// - Conditional set decodes from 1010111W, register, condition; takes 5 cycles.
// - Test ORs operand with zero, sets Z and S, sets P/V on byte tests only, writes nothing back.
// - Register test takes 7 cycles, long-word register test 13.
// - Indirect form needs nonzero register; 8 cycles, long 13.
// - Direct word/byte test: 11 nonsegmented, 12 short, 14 long segmented.
// - Direct long test: 16 nonsegmented, 17 short, 19 long segmented.
// - Indexed word/byte test needs nonzero index; 12 cycles, 15 long segmented.
// - Indexed long test: 17 cycles, 20 with long segmented address.
// - Indirect pointer is a word register, or a pair when segmented.
`include "ctx_consts.vh"
module ctx_exec (
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR
);

  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg [2:0] ctrl_q;
  reg [15:0] instr_q;
  reg [15:0] ext_q;
  reg [31:0] opnd_q;
  reg [7:0] flags_q;
  reg [31:0] result_q;
  reg [3:0] stat_q;
  reg [2:0] state_q;
  reg [4:0] cnt_q;
  reg start_q;

  wire wr = PSEL && PENABLE && PWRITE && !PREADY;
  wire rd = PSEL && PENABLE && !PWRITE && !PREADY;
  reg mapped;
  reg [31:0] rdata_d;

  always @* begin
    mapped = 1'b1;
    rdata_d = 32'h0000_0000;
    case (PADDR)
      `CTX_OFS_CTRL: rdata_d = {29'h0000_0000, ctrl_q};
      `CTX_OFS_INSTR: rdata_d = {16'h0000, instr_q};
      `CTX_OFS_EXT: rdata_d = {16'h0000, ext_q};
      `CTX_OFS_OPND: rdata_d = opnd_q;
      `CTX_OFS_FLAGS: rdata_d = {24'h00_0000, flags_q};
      `CTX_OFS_RESULT: rdata_d = result_q;
      `CTX_OFS_STATUS: rdata_d = {28'h000_0000, stat_q};
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire [1:0] mode = instr_q[15:14];
  wire size_w = instr_q[8];
  wire [3:0] rfield = instr_q[7:4];
  wire [3:0] lonib = instr_q[3:0];
  wire is_cset = (instr_q[15:9] == `CTX_OP_CSET);
  wire is_test_wb = (instr_q[13:9] == `CTX_OP_TEST_WB) && (lonib == `CTX_NIB_TEST_WB);
  wire is_test_l = (instr_q[13:8] == `CTX_OP_TEST_L) && (lonib == `CTX_NIB_TEST_L);
  wire is_test = (is_test_wb || is_test_l) && (mode != 2'h3);
  wire seg = ctrl_q[`CTX_CTRL_SEG];
  wire long_segment_form = seg && ext_q[15];
  // Indirect pointer of zero is refused; the pair/word choice only affects address width.
  wire ir_bad = (mode == `CTX_MODE_IR) && (rfield == 4'h0);

  reg [4:0] cyc;
  always @* begin
    cyc = 5'd1;
    if (is_cset) begin
      cyc = `CTX_CYC_CSET;
    end else if (mode == `CTX_MODE_R) begin
      cyc = is_test_l ? `CTX_CYC_R_L : `CTX_CYC_R_WB;
    end else if (mode == `CTX_MODE_IR) begin
      cyc = is_test_l ? `CTX_CYC_IR_L : `CTX_CYC_IR_WB;
    end else if (rfield == 4'h0) begin
      if (is_test_l) begin
        cyc = !seg ? `CTX_CYC_DA_L_NS : (long_segment_form ? `CTX_CYC_DA_L_SL :
          `CTX_CYC_DA_L_SS);
      end else begin
        cyc = !seg ? `CTX_CYC_DA_WB_NS : (long_segment_form ? `CTX_CYC_DA_WB_SL :
          `CTX_CYC_DA_WB_SS);
      end
    end else begin
      if (is_test_l) begin
        cyc = long_segment_form ? `CTX_CYC_X_L_SL : `CTX_CYC_X_L_S;
      end else begin
        cyc = long_segment_form ? `CTX_CYC_X_WB_SL : `CTX_CYC_X_WB_S;
      end
    end
  end

  // ****************************************************************
  // Condition evaluation
  // ****************************************************************
  wire fc = flags_q[`CTX_FLG_C];
  wire fz = flags_q[`CTX_FLG_Z];
  wire fs = flags_q[`CTX_FLG_S];
  wire fv = flags_q[`CTX_FLG_PV];
  reg cond_true;
  // Standard sixteen-code table; codes outside the visible encodings follow usual practice.
  always @* begin
    case (lonib)
      4'h0: cond_true = 1'b0;
      4'h1: cond_true = fs ^ fv;
      4'h2: cond_true = fz | (fs ^ fv);
      4'h3: cond_true = fc | fz;
      4'h4: cond_true = fv;
      4'h5: cond_true = fs;
      4'h6: cond_true = fz;
      4'h7: cond_true = fc;
      4'h8: cond_true = 1'b1;
      4'h9: cond_true = ~(fs ^ fv);
      4'ha: cond_true = ~(fz | (fs ^ fv));
      4'hb: cond_true = ~(fc | fz);
      4'hc: cond_true = ~fv;
      4'hd: cond_true = ~fs;
      4'he: cond_true = ~fz;
      default: cond_true = ~fc;
    endcase
  end

  // ****************************************************************
  // Test datapath
  // ****************************************************************
  reg [31:0] tres;
  reg tz;
  reg ts;
  always @* begin
    if (is_test_l) begin
      tres = opnd_q | 32'h0000_0000;
      ts = tres[31];
    end else if (size_w) begin
      tres = {16'h0000, opnd_q[15:0] | 16'h0000};
      ts = tres[15];
    end else begin
      tres = {24'h00_0000, opnd_q[7:0] | 8'h00};
      ts = tres[7];
    end
    tz = (tres == 32'h0000_0000);
  end
  wire tpar = ~(^tres[7:0]);

  // ****************************************************************
  // Sequencer and register writes
  // ****************************************************************
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 3'h0;
      instr_q <= 16'h0000;
      ext_q <= 16'h0000;
      opnd_q <= `CTX_RESET_WORD;
      flags_q <= 8'h00;
      result_q <= `CTX_RESET_WORD;
      stat_q <= 4'h0;
      state_q <= ST_IDLE;
      cnt_q <= 5'd0;
      start_q <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      if (rd) begin
        PRDATA <= rdata_d;
      end
      start_q <= 1'b0;
      if (wr && state_q != ST_RUN) begin
        case (PADDR)
          `CTX_OFS_CTRL: begin
            ctrl_q <= {PWDATA[2:1], 1'b0};
            start_q <= PWDATA[`CTX_CTRL_START];
          end
          `CTX_OFS_INSTR: instr_q <= PWDATA[15:0];
          `CTX_OFS_EXT: ext_q <= PWDATA[15:0];
          `CTX_OFS_OPND: opnd_q <= PWDATA;
          `CTX_OFS_FLAGS: flags_q <= PWDATA[7:0];
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (start_q) begin
            stat_q <= {1'b0, 1'b0, 1'b0, 1'b1};
            if ((!is_cset && !is_test) || (is_test && ir_bad)) begin
              stat_q <= 4'b0110;
              state_q <= ST_DONE;
            end else begin
              cnt_q <= cyc - 5'd1;
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (cnt_q <= 5'd1) begin
            state_q <= ST_DONE;
            if (is_cset) begin
              // Only bit 0 may change; a false condition keeps it.
              result_q <= {opnd_q[31:1], opnd_q[0] | cond_true};
              stat_q <= 4'b1010;
            end else begin
              result_q <= opnd_q;
              flags_q[`CTX_FLG_Z] <= tz;
              flags_q[`CTX_FLG_S] <= ts;
              if (!is_test_l && !size_w) begin
                flags_q[`CTX_FLG_PV] <= tpar;
              end
              stat_q <= 4'b0010;
            end
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // ctx_exec

// ===== tb/ctx_exec_asserts.sv
`timescale 1ns/100ps
module ctx_exec_asserts (
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR
);
  // ****
  // Bus answer checks
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("no ready");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("stray ready");
  a_setup_quiet: assert property (PSEL && !PENABLE |=> !PREADY) else $error("early ready");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_err_hole: assert property (PSEL && PENABLE && !PREADY && PADDR == 8'h10 |=> PSLVERR)
    else $error("hole not refused");
  a_map_ok: assert property (PSEL && PENABLE && !PREADY && PADDR[1:0] == 2'h0
    && PADDR <= 8'h1c && PADDR != 8'h10 |=> !PSLVERR) else $error("mapped refused");
  a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("err data");
endmodule // ctx_exec_asserts
bind ctx_exec ctx_exec_asserts ctx_exec_asserts_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR));

// ===== tb/tb_ctx_exec.sv
`timescale 1ns/100ps
`include "ctx_consts.vh"
module tb_ctx_exec;
  reg CLK, RST_N, PSEL, PENABLE, PWRITE;
  reg [7:0] PADDR;
  reg [31:0] PWDATA;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR;
  int err_total = 0;
  int num_checks = 0;
  int tick = 0;
  logic [31:0] rv;
  logic re;
  ctx_exec ctx_exec_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
  // ****
  // Clock, bus master and checks
  // ****
  initial begin
    CLK = 0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) tick <= tick + 1;
  task test_done;
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // An idle edge follows each transfer so no signal is assigned twice in one step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rv = PRDATA;
    re = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (n >= 20) begin
      err_total++;
      test_done;
    end
    @(posedge CLK);
  endtask
  // Polling costs four cycles, so the count is only checked to a small window.
  task automatic run(input logic [15:0] ins, input logic [1:0] sg, input logic [31:0] op,
      input logic [31:0] fl, input int cyc, input logic [31:0] res, input logic [31:0] fo);
    int t0;
    int dt;
    bus(1, `CTX_OFS_INSTR, {16'h0, ins});
    bus(1, `CTX_OFS_OPND, op);
    bus(1, `CTX_OFS_FLAGS, fl);
    bus(1, `CTX_OFS_EXT, {16'h0, sg[1], 15'h0});
    bus(1, `CTX_OFS_CTRL, {29'h0, sg[1], sg[0], 1'b1});
    t0 = tick;
    do bus(0, `CTX_OFS_STATUS, 0); while (rv[`CTX_ST_DONE] !== 1'b1 && tick - t0 < 100);
    dt = tick - t0;
    if (dt >= 100) begin
      err_total++;
      test_done;
    end
    chk("cycles", {31'h0, dt >= cyc - 2 && dt <= cyc + 5}, 1);
    chk("writeback", {31'h0, rv[`CTX_ST_WB]}, {31'h0, ins[15:9] == 7'h57});
    bus(0, `CTX_OFS_RESULT, 0);
    chk("result", rv, res);
    bus(0, `CTX_OFS_FLAGS, 0);
    chk("flags", rv & 32'hf0, fo);
  endtask
  task t_cset;
    run(16'haf18, 2'h1, 32'h1234, 32'hc0, 5, 32'h1235, 32'hc0);
    run(16'hae10, 2'h0, 32'h1235, 32'h40, 5, 32'h1235, 32'h40);
    run(16'hae18, 2'h3, 32'hff00, 32'h00, 5, 32'hff01, 32'h00);
  endtask
  task t_test_reg;
    run(16'h8c14, 2'h0, 32'h0003, 32'h80, 7, 32'h0003, 32'h90);
    run(16'h8d14, 2'h0, 32'h8000, 32'h10, 7, 32'h8000, 32'h30);
    run(16'h8c14, 2'h0, 32'h0100, 32'h20, 7, 32'h0100, 32'h50);
    run(16'h9c18, 2'h0, 32'h0, 32'h00, 13, 32'h0, 32'h40);
  endtask
  task t_test_mem;
    run(16'h0d14, 2'h1, 32'h0001, 32'h40, 8, 32'h0001, 32'h00);
    run(16'h4d04, 2'h3, 32'h7fff, 32'h00, 14, 32'h7fff, 32'h00);
    run(16'h5c08, 2'h0, 32'h0001, 32'h40, 16, 32'h0001, 32'h00);
    run(16'h4d14, 2'h0, 32'h0001, 32'h40, 12, 32'h0001, 32'h00);
    run(16'h5c18, 2'h1, 32'h8000_0000, 32'h00, 17, 32'h8000_0000, 32'h20);
  endtask
  task t_refuse;
    bus(1, `CTX_OFS_INSTR, 32'h0c04);
    bus(1, `CTX_OFS_CTRL, 32'h1);
    repeat (10) bus(0, `CTX_OFS_STATUS, 0);
    chk("illegal", {31'h0, rv[`CTX_ST_ILL]}, 1);
    bus(0, 8'h10, 0);
    chk("hole err", {31'h0, re}, 1);
    chk("hole data", rv, 0);
  endtask
  initial begin
    RST_N = 0;
    PSEL = 0;
    PENABLE = 0;
    PWRITE = 0;
    PADDR = 0;
    PWDATA = 0;
    repeat (3) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    bus(0, `CTX_OFS_RESULT, 0);
    chk("reset result", rv, `CTX_RESET_WORD);
    t_cset;
    t_test_reg;
    t_test_mem;
    t_refuse;
    test_done;
  end
endmodule // tb_ctx_exec
